/* File: src/nvmws_defines.svh */
// Offsets, field positions, reset values and timing counts of the write sequencer
`ifndef NVMWS_DEFINES_SVH
`define NVMWS_DEFINES_SVH

// Special-function register offsets on the CPU register port
`define NVMWS_ADR_CTL       16'h0760
`define NVMWS_ADR_LO        16'h0762
`define NVMWS_ADR_UP        16'h0764
`define NVMWS_ADR_KEY       16'h0766

// Operation control fields
`define NVMWS_BIT_WR        15
`define NVMWS_BIT_WRITE_ENABLE_BIT      14
`define NVMWS_BIT_WRITE_ERROR_BIT     13
`define NVMWS_BIT_WRITE_TIMING_SELECT      8
`define NVMWS_CTL_RST       16'h0000
`define NVMWS_KEY_RST       16'h0000

// Unlock key values
`define NVMWS_KEY_FIRST     8'h55
`define NVMWS_KEY_SECOND    8'haa

// Operation select codes
`define NVMWS_OP_BLK_ERASE  7'h45
`define NVMWS_OP_WORD_ERASE 7'h44
`define NVMWS_OP_WORD_PROG  7'h04
`define NVMWS_OP_BLK_PROG   7'h0a

// Data EEPROM window, 0x7ff000 to 0x7ffffe
`define NVMWS_EE_PAGE       8'h7f
`define NVMWS_EE_LO_BASE    16'hf000
`define NVMWS_EE_AW         12
`define NVMWS_BLK_WORDS     16
`define NVMWS_ERASED        16'hffff

// Cycle time: 2 ms at a 25 MHz system clock
`define NVMWS_CYCLE_US      2000
`define NVMWS_CLK_KHZ       25000
`define NVMWS_CYCLE_CLKS    ((`NVMWS_CYCLE_US * `NVMWS_CLK_KHZ) / 1000)

`endif

/* File: src/nvmws_pkg.sv */
// Types shared by the write sequencer modules
package nvmws_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} nvmws_key_type;

  typedef enum logic [2:0] {
    OP_FLASH,
    OP_WORD_ERASE,
    OP_BLOCK_ERASE,
    OP_WORD_PROG,
    OP_BLOCK_PROG
  } nvmws_op_type;

  typedef enum logic [1:0] {ARR_IDLE, ARR_APPLY, ARR_WAIT} nvmws_arr_type;

endpackage

/* File: src/nvmws_op_if.sv */
// Carrier between the register front end and the cell array
`timescale 1ns/10ps
interface nvmws_op_if
  import nvmws_pkg::*;
#(
  parameter int AW = 12,
  parameter int LW = 4
);
  logic         start;
  nvmws_op_type op;
  logic [AW-1:0] adr;
  logic         abort;
  logic         lat_we;
  logic [LW-1:0] lat_idx;
  logic [15:0]  lat_data;
  logic [AW-1:0] rd_adr;
  logic [15:0]  rd_data;
  logic         done;

  modport ctl (
    output start, op, adr, abort, lat_we, lat_idx, lat_data, rd_adr,
    input  rd_data, done
  );
  modport arr (
    input  start, op, adr, abort, lat_we, lat_idx, lat_data, rd_adr,
    output rd_data, done
  );
endinterface

/* File: src/nvmws_cell_array.sv */
// Data EEPROM cells, write latches and the erase/program cycle timer
`timescale 1ns/10ps
`include "nvmws_defines.svh"
module nvmws_cell_array
  import nvmws_pkg::*;
#(
  parameter int CYCLE_CLKS = `NVMWS_CYCLE_CLKS,
  parameter int AW         = `NVMWS_EE_AW,
  parameter int BLK_WORDS  = `NVMWS_BLK_WORDS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  nvmws_op_if.arr   op
);
  localparam int LW = $clog2(BLK_WORDS);
  localparam int TW = $clog2(CYCLE_CLKS + 1);

  nvmws_arr_type st_r, st_nxt;
  nvmws_op_type  opk_r, opk_nxt;
  logic [AW-1:0] base_r, base_nxt;
  logic [LW-1:0] step_r, step_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic          done_r, done_nxt;
  logic          blk;
  logic          erase;
  logic          mem_we;
  logic [AW-1:0] mem_a;
  logic [15:0]   mem_d;
  logic [15:0]   mem [2**AW];
  logic [15:0]   lat [BLK_WORDS];

  assign blk        = (opk_r == OP_BLOCK_ERASE) || (opk_r == OP_BLOCK_PROG);
  assign erase      = (opk_r == OP_BLOCK_ERASE) || (opk_r == OP_WORD_ERASE);
  // Reads during a cycle may see half-written cells
  assign op.rd_data = mem[op.rd_adr];
  assign op.done    = done_r;

  always_comb begin
    st_nxt   = st_r;
    opk_nxt  = opk_r;
    base_nxt = base_r;
    step_nxt = step_r;
    tmr_nxt  = tmr_r;
    done_nxt = 1'b0;
    mem_we   = 1'b0;
    mem_a    = blk ? {base_r[AW-1:LW], step_r} : base_r;
    mem_d    = erase ? `NVMWS_ERASED : lat[blk ? step_r : base_r[LW-1:0]];
    unique case (st_r)
      ARR_IDLE: begin
        if (op.start) begin
          opk_nxt  = op.op;
          base_nxt = op.adr;
          step_nxt = '0;
          tmr_nxt  = '0;
          st_nxt   = (op.op == OP_FLASH) ? ARR_WAIT : ARR_APPLY;
        end
      end
      ARR_APPLY: begin
        tmr_nxt = tmr_r + 1'b1;
        mem_we  = 1'b1;
        if (!blk || step_r == LW'(BLK_WORDS - 1)) begin
          st_nxt = ARR_WAIT;
        end else begin
          step_nxt = step_r + 1'b1;
        end
      end
      ARR_WAIT: begin
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TW'(CYCLE_CLKS - 1)) begin
          done_nxt = 1'b1;
          st_nxt   = ARR_IDLE;
        end
      end
    endcase
    if (op.abort) begin
      st_nxt   = ARR_IDLE;
      done_nxt = 1'b0;
      mem_we   = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r   <= ARR_IDLE;
      opk_r  <= OP_FLASH;
      base_r <= '0;
      step_r <= '0;
      tmr_r  <= '0;
      done_r <= 1'b0;
    end else if (i_ce) begin
      st_r   <= st_nxt;
      opk_r  <= opk_nxt;
      base_r <= base_nxt;
      step_r <= step_nxt;
      tmr_r  <= tmr_nxt;
      done_r <= done_nxt;
    end
  end

  // Cell storage has no reset: its contents are nonvolatile
  always_ff @(posedge i_clk) begin
    if (i_ce && mem_we) begin
      mem[mem_a] <= mem_d;
    end
    if (i_ce && op.lat_we) begin
      lat[op.lat_idx] <= op.lat_data;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_cycle_length: assert property (
    $rose(done_r) |-> $past(tmr_r) == TW'(CYCLE_CLKS - 1)
  ) else $error("Cycle done at the wrong count");
  a_block_span: assert property (
    i_ce && !op.abort && st_r == ARR_APPLY && blk && step_r != LW'(BLK_WORDS - 1)
      |=> st_r == ARR_APPLY && step_r == $past(step_r) + 1'b1
  ) else $error("Block operation left early");
  a_word_single: assert property (
    i_ce && !op.abort && st_r == ARR_APPLY && !blk |=> st_r == ARR_WAIT
  ) else $error("Word operation wrote more than once");
endmodule

/* File: src/nvmws_top.sv */
// Nonvolatile memory write sequencer: control registers, unlock and table port
`timescale 1ns/10ps
// Functional notes
// - Erase or program starts only after keys 0x55 then 0xAA are written.
// - Data EEPROM supports word and 16-word block read, erase, program; the table port here reads one word at a time.
// - Up to 2K words, addressed 0x7ff000 to 0x7ffffe via both address registers; erase and program here use only the low one.
// - A cycle takes nominally 2 ms; hardware signals its end.
// - Data EEPROM cycles never stall the CPU.
// - Reads during a cycle may return arbitrary data.
// - Start bit 15 is set only by software, cleared only by hardware.
// - Enable bit 14 must be set for writes; clear after power-up.
// - Master clear or watchdog reset mid-write sets error bit 13, keeps address.
// - Completion sets the done flag; only software clears it.
// - Table read returns the word at the page-and-pointer address.
// - 0x4045 selects block erase, 0x4044 word erase, both with writes enabled.
// - Control and key registers reset to zero, except error bit 13 set by a mid-write master clear or watchdog reset.
// - Keys count only as two consecutive writes to the key register.
// - Start needs the enable bit set by an earlier write.
// - Address registers capture the last table instruction's address.
// - Program flash cycles last nominally 2 ms and stall the CPU.
`include "nvmws_defines.svh"
module nvmws_top
  import nvmws_pkg::*;
#(
  parameter int CYCLE_CLKS = `NVMWS_CYCLE_CLKS,
  parameter int AW         = `NVMWS_EE_AW,
  parameter int BLK_WORDS  = `NVMWS_BLK_WORDS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_master_clear_reset_wdt_rst,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [15:0] i_sfr_addr,
  input  wire logic [15:0] i_sfr_wdata,
  output logic      [15:0] o_sfr_rdata,
  input  wire logic        i_tbl_rd,
  input  wire logic        i_tbl_wr,
  input  wire logic [7:0]  i_tbl_page,
  input  wire logic [15:0] i_tbl_ea,
  input  wire logic [15:0] i_tbl_wdata,
  output logic      [15:0] o_tbl_rdata,
  input  wire logic        i_done_flag_clr,
  output logic             o_nv_done_flag,
  output logic             o_cpu_stall
);
  localparam int LW = $clog2(BLK_WORDS);

  nvmws_key_type key_r, key_nxt;
  logic [15:0]   ctl_r, ctl_nxt;
  logic [15:0]   adr_lo_r, adr_lo_nxt;
  logic [7:0]    adr_up_r, adr_up_nxt;
  logic          done_r, done_nxt;
  logic          stall_r, stall_nxt;
  logic [15:0]   sfr_rd_r, sfr_rd_nxt;
  logic [15:0]   tbl_rd_r, tbl_rd_nxt;
  logic          start;
  logic          tbl_in_ee;
  nvmws_op_type  op_kind;

  nvmws_op_if #(.AW(AW), .LW(LW)) op_bus ();

  nvmws_cell_array #(
    .CYCLE_CLKS (CYCLE_CLKS),
    .AW         (AW),
    .BLK_WORDS  (BLK_WORDS)
  ) u_cells (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .op      (op_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic nvmws_op_type decode_op(input logic [6:0] sel);
    nvmws_op_type k;
    k = OP_FLASH;
    case (sel)
      `NVMWS_OP_BLK_ERASE:  k = OP_BLOCK_ERASE;
      `NVMWS_OP_WORD_ERASE: k = OP_WORD_ERASE;
      `NVMWS_OP_WORD_PROG:  k = OP_WORD_PROG;
      `NVMWS_OP_BLK_PROG:   k = OP_BLOCK_PROG;
      default:              k = OP_FLASH;
    endcase
    return k;
  endfunction

  function automatic logic in_ee(input logic [7:0] up, input logic [15:0] lo);
    return (up == `NVMWS_EE_PAGE) && (lo >= `NVMWS_EE_LO_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link to the cell array

  assign op_bus.start    = start && i_ce;
  assign op_bus.op       = op_kind;
  assign op_bus.adr      = adr_lo_r[AW:1];
  assign op_bus.abort    = i_master_clear_reset_wdt_rst && i_ce;
  assign op_bus.lat_we   = i_tbl_wr && tbl_in_ee && i_ce;
  assign op_bus.lat_idx  = i_tbl_ea[LW:1];
  assign op_bus.lat_data = i_tbl_wdata;
  assign op_bus.rd_adr   = i_tbl_ea[AW:1];

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    key_nxt    = key_r;
    ctl_nxt    = ctl_r;
    adr_lo_nxt = adr_lo_r;
    adr_up_nxt = adr_up_r;
    done_nxt   = done_r;
    stall_nxt  = stall_r;
    sfr_rd_nxt = sfr_rd_r;
    tbl_rd_nxt = tbl_rd_r;
    start      = 1'b0;
    op_kind    = decode_op(i_sfr_wdata[6:0]);
    tbl_in_ee  = in_ee(i_tbl_page, i_tbl_ea);

    if (i_tbl_rd || i_tbl_wr) begin
      adr_lo_nxt = i_tbl_ea;
      adr_up_nxt = i_tbl_page;
    end
    if (i_tbl_rd) begin
      // Outside the EEPROM window this block has nothing to return
      tbl_rd_nxt = tbl_in_ee ? op_bus.rd_data : 16'h0000;
    end

    if (i_sfr_rd) begin
      if (i_sfr_addr == `NVMWS_ADR_CTL) begin
        sfr_rd_nxt = ctl_r;
      end else if (i_sfr_addr == `NVMWS_ADR_LO) begin
        sfr_rd_nxt = adr_lo_r;
      end else if (i_sfr_addr == `NVMWS_ADR_UP) begin
        sfr_rd_nxt = {8'h00, adr_up_r};
      end else begin
        // Key register is write only and reads as zero
        sfr_rd_nxt = 16'h0000;
      end
    end

    if (i_sfr_wr) begin
      if (i_sfr_addr == `NVMWS_ADR_KEY) begin
        if (i_sfr_wdata[7:0] == `NVMWS_KEY_FIRST) begin
          key_nxt = KEY_GOT_FIRST;
        end else if (i_sfr_wdata[7:0] == `NVMWS_KEY_SECOND && key_r == KEY_GOT_FIRST) begin
          key_nxt = KEY_ARMED;
        end else begin
          key_nxt = KEY_IDLE;
        end
      end else begin
        // Any other write spends or cancels the unlock
        key_nxt = KEY_IDLE;
      end

      if (i_sfr_addr == `NVMWS_ADR_CTL) begin
        ctl_nxt[`NVMWS_BIT_WRITE_ENABLE_BIT]  = i_sfr_wdata[`NVMWS_BIT_WRITE_ENABLE_BIT];
        ctl_nxt[`NVMWS_BIT_WRITE_ERROR_BIT] = i_sfr_wdata[`NVMWS_BIT_WRITE_ERROR_BIT];
        ctl_nxt[`NVMWS_BIT_WRITE_TIMING_SELECT]  = i_sfr_wdata[`NVMWS_BIT_WRITE_TIMING_SELECT];
        ctl_nxt[6:0]              = i_sfr_wdata[6:0];
        // Enable is checked as it stood before this write
        if (i_sfr_wdata[`NVMWS_BIT_WR] && ctl_r[`NVMWS_BIT_WRITE_ENABLE_BIT] &&
            key_r == KEY_ARMED && !ctl_r[`NVMWS_BIT_WR]) begin
          ctl_nxt[`NVMWS_BIT_WR] = 1'b1;
          start                  = 1'b1;
          stall_nxt              = (op_kind == OP_FLASH);
        end
      end else if (i_sfr_addr == `NVMWS_ADR_LO) begin
        adr_lo_nxt = i_sfr_wdata;
      end else if (i_sfr_addr == `NVMWS_ADR_UP) begin
        adr_up_nxt = i_sfr_wdata[7:0];
      end
    end

    // Clear first so a completion in the same cycle is kept
    if (i_done_flag_clr) begin
      done_nxt = 1'b0;
    end
    if (op_bus.done) begin
      ctl_nxt[`NVMWS_BIT_WR] = 1'b0;
      done_nxt               = 1'b1;
      stall_nxt              = 1'b0;
    end

    if (i_master_clear_reset_wdt_rst) begin
      ctl_nxt                   = `NVMWS_CTL_RST;
      ctl_nxt[`NVMWS_BIT_WRITE_ERROR_BIT] = ctl_r[`NVMWS_BIT_WR] && !op_bus.done;
      key_nxt                   = KEY_IDLE;
      adr_lo_nxt                = adr_lo_r;
      adr_up_nxt                = adr_up_r;
      stall_nxt                 = 1'b0;
      start                     = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_r    <= KEY_IDLE;
      ctl_r    <= `NVMWS_CTL_RST;
      adr_lo_r <= 16'h0000;
      adr_up_r <= 8'h00;
      done_r   <= 1'b0;
      stall_r  <= 1'b0;
      sfr_rd_r <= 16'h0000;
      tbl_rd_r <= 16'h0000;
    end else if (i_ce) begin
      key_r    <= key_nxt;
      ctl_r    <= ctl_nxt;
      adr_lo_r <= adr_lo_nxt;
      adr_up_r <= adr_up_nxt;
      done_r   <= done_nxt;
      stall_r  <= stall_nxt;
      sfr_rd_r <= sfr_rd_nxt;
      tbl_rd_r <= tbl_rd_nxt;
    end
  end

  assign o_sfr_rdata    = sfr_rd_r;
  assign o_tbl_rdata    = tbl_rd_r;
  assign o_nv_done_flag = done_r;
  assign o_cpu_stall    = stall_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_start_needs_key: assert property (
    $rose(ctl_r[`NVMWS_BIT_WR]) |-> $past(key_r) == KEY_ARMED
  ) else $error("Start bit set without unlock");

  a_start_needs_write_enable_bit: assert property (
    $rose(ctl_r[`NVMWS_BIT_WR]) |-> $past(ctl_r[`NVMWS_BIT_WRITE_ENABLE_BIT])
  ) else $error("Start bit set without prior enable");

  a_wr_held_busy: assert property (
    ctl_r[`NVMWS_BIT_WR] && !op_bus.done && !i_master_clear_reset_wdt_rst |=> ctl_r[`NVMWS_BIT_WR]
  ) else $error("Start bit dropped before completion");

  a_done_clears_wr: assert property (
    i_ce && op_bus.done && !i_master_clear_reset_wdt_rst
      |=> !ctl_r[`NVMWS_BIT_WR] && o_nv_done_flag
  ) else $error("Completion did not clear start and set flag");

  a_flag_sticks: assert property (
    o_nv_done_flag && !i_done_flag_clr |=> o_nv_done_flag
  ) else $error("Done flag cleared by hardware");

  a_err_on_abort: assert property (
    i_ce && i_master_clear_reset_wdt_rst && ctl_r[`NVMWS_BIT_WR] && !op_bus.done
      |=> ctl_r[`NVMWS_BIT_WRITE_ERROR_BIT] && !ctl_r[`NVMWS_BIT_WR] && $stable(adr_lo_r)
  ) else $error("Interrupted write not recorded");

  a_key_cleared_rst: assert property (
    i_ce && i_master_clear_reset_wdt_rst |=> key_r == KEY_IDLE && !ctl_r[`NVMWS_BIT_WRITE_ENABLE_BIT]
  ) else $error("Reset left key or control set");

  a_ee_no_stall: assert property (
    op_bus.start && op_kind != OP_FLASH |=> ctl_r[`NVMWS_BIT_WR] && !o_cpu_stall
  ) else $error("EEPROM cycle stalled the CPU");

  a_flash_stalls: assert property (
    op_bus.start && op_kind == OP_FLASH |=> o_cpu_stall && ctl_r[`NVMWS_BIT_WR]
  ) else $error("Flash cycle did not stall the CPU");

  a_tbl_capture: assert property (
    i_ce && (i_tbl_rd || i_tbl_wr) && !i_sfr_wr && !i_master_clear_reset_wdt_rst
      |=> adr_lo_r == $past(i_tbl_ea) && adr_up_r == $past(i_tbl_page)
  ) else $error("Table address not captured");

  a_start_by_write: assert property (
    $rose(ctl_r[`NVMWS_BIT_WR]) |-> $past(i_sfr_wr) && $past(i_sfr_addr) == `NVMWS_ADR_CTL
  ) else $error("Start bit set without a control write");

  a_other_wr_cancels: assert property (
    i_ce && i_sfr_wr && i_sfr_addr != `NVMWS_ADR_KEY |=> key_r == KEY_IDLE
  ) else $error("Unlock survived another register write");

  a_arm_after_first: assert property (
    i_ce && key_r == KEY_IDLE |=> key_r != KEY_ARMED
  ) else $error("Unlock armed without the first key");

  // Set must win over a clear landing in the same cycle
  a_done_sets_flag: assert property (
    i_ce && op_bus.done |=> o_nv_done_flag
  ) else $error("Completion did not raise the flag");

  a_outside_reads_zero: assert property (
    i_ce && i_tbl_rd && i_tbl_page != `NVMWS_EE_PAGE |=> o_tbl_rdata == 16'h0000
  ) else $error("Table read outside the window returned data");
endmodule

/* File: test/nvmws_cpu_model.sv */
// CPU-side model issuing register and table accesses to the sequencer
`timescale 1ns/10ps
`include "nvmws_defines.svh"
module nvmws_cpu_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_sfr_rdata,
  input  wire logic [15:0] i_tbl_rdata,
  output logic             o_sfr_wr,
  output logic             o_sfr_rd,
  output logic      [15:0] o_sfr_addr,
  output logic      [15:0] o_sfr_wdata,
  output logic             o_tbl_rd,
  output logic             o_tbl_wr,
  output logic      [7:0]  o_tbl_page,
  output logic      [15:0] o_tbl_ea,
  output logic      [15:0] o_tbl_wdata
);
  initial begin
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_addr = 16'h0000;
    o_sfr_wdata = 16'h0000;
    o_tbl_rd = 1'b0;
    o_tbl_wr = 1'b0;
    o_tbl_page = 8'h00;
    o_tbl_ea = 16'h0000;
    o_tbl_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  // One strobe cycle; write data inverted afterwards so stale values never help
  task automatic sfr(input logic wr, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge i_clk) #1;
    o_sfr_addr = a;
    o_sfr_wdata = d;
    o_sfr_wr = wr;
    o_sfr_rd = !wr;
    @(posedge i_clk) #1;
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_wdata = ~d;
    q = i_sfr_rdata;
  endtask
  task automatic tbl(input logic wr, input logic [7:0] p, input logic [15:0] ea,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge i_clk) #1;
    o_tbl_page = p;
    o_tbl_ea = ea;
    o_tbl_wdata = d;
    o_tbl_wr = wr;
    o_tbl_rd = !wr;
    @(posedge i_clk) #1;
    o_tbl_wr = 1'b0;
    o_tbl_rd = 1'b0;
    o_tbl_wdata = ~d;
    q = i_tbl_rdata;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic unlock_start(input logic [15:0] ctl);
    logic [15:0] q;
    sfr(1'b1, `NVMWS_ADR_CTL, ctl, q);
    sfr(1'b1, `NVMWS_ADR_KEY, 16'h0055, q);
    sfr(1'b1, `NVMWS_ADR_KEY, 16'h00aa, q);
    sfr(1'b1, `NVMWS_ADR_CTL, ctl | 16'h8000, q);
    // Two idle cycles after the start write
    repeat (2) @(posedge i_clk);
    #1;
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the write sequencer
`timescale 1ns/10ps
`include "nvmws_defines.svh"
module tb;
  import nvmws_pkg::*;
  localparam int CYC = 40;
  localparam logic [15:0] C = `NVMWS_ADR_CTL;
  localparam logic [15:0] K = `NVMWS_ADR_KEY;
  logic        clk, rst_n, master_clear_reset, clr, sfr_wr, sfr_rd, tbl_rd, tbl_wr, done_flag, stall, ce;
  logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, tbl_ea, tbl_wdata, tbl_rdata, q;
  logic [7:0]  tbl_page;
  int          mismatches, n_tests;

  nvmws_top #(.CYCLE_CLKS(CYC)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_master_clear_reset_wdt_rst(master_clear_reset), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_addr(sfr_addr),
    .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(sfr_rdata), .i_tbl_rd(tbl_rd),
    .i_tbl_wr(tbl_wr), .i_tbl_page(tbl_page), .i_tbl_ea(tbl_ea),
    .i_tbl_wdata(tbl_wdata), .o_tbl_rdata(tbl_rdata), .i_done_flag_clr(clr),
    .o_nv_done_flag(done_flag), .o_cpu_stall(stall));
  nvmws_cpu_model cpu (.i_clk(clk), .i_sfr_rdata(sfr_rdata), .i_tbl_rdata(tbl_rdata),
    .o_sfr_wr(sfr_wr), .o_sfr_rd(sfr_rd), .o_sfr_addr(sfr_addr),
    .o_sfr_wdata(sfr_wdata), .o_tbl_rd(tbl_rd), .o_tbl_wr(tbl_wr),
    .o_tbl_page(tbl_page), .o_tbl_ea(tbl_ea), .o_tbl_wdata(tbl_wdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic pulse(input bit is_master_clear_reset);
    @(posedge clk) #1;
    if (is_master_clear_reset) master_clear_reset = 1'b1;
    else clr = 1'b1;
    @(posedge clk) #1;
    master_clear_reset = 1'b0;
    clr = 1'b0;
  endtask
  // Unlock, start, time the cycle and clear the flag afterwards
  task automatic run_op(input logic [15:0] ctl, input logic exp_stall);
    int n;
    n = 0;
    cpu.unlock_start(ctl);
    chk("stall", {15'h0, stall}, {15'h0, exp_stall});
    // Completion is awaited on the flag, never assumed from time
    while (done_flag !== 1'b1 && n < 4 * CYC) begin
      @(posedge clk) #1;
      n++;
    end
    chk("cycle length", n[15:0], 16'(CYC - 1));
    chk("stall after", {15'h0, stall}, 16'h0);
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("ctl after op", q, ctl);
    repeat (3) @(posedge clk);
    #1;
    chk("flag sticky", {15'h0, done_flag}, 16'h1);
    pulse(1'b0);
    chk("flag cleared", {15'h0, done_flag}, 16'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("ctl reset", q, `NVMWS_CTL_RST);
    cpu.sfr(1'b0, K, 16'h0, q);
    chk("key reset", q, `NVMWS_KEY_RST);
    chk("flag reset", {15'h0, done_flag}, 16'h0);
    $display("Test reset done");
  endtask
  task automatic t_word;
    cpu.tbl(1'b1, 8'h7f, 16'hf010, 16'h1234, q);
    run_op(16'h4044, 1'b0);
    cpu.tbl(1'b0, 8'h7f, 16'hf010, 16'h0, q);
    chk("erased word", q, `NVMWS_ERASED);
    run_op(16'h4004, 1'b0);
    cpu.tbl(1'b0, 8'h7f, 16'hf010, 16'h0, q);
    chk("programmed word", q, 16'h1234);
    cpu.sfr(1'b0, `NVMWS_ADR_LO, 16'h0, q);
    chk("addr low", q, 16'hf010);
    cpu.sfr(1'b0, `NVMWS_ADR_UP, 16'h0, q);
    chk("addr upper", q, 16'h007f);
    cpu.tbl(1'b0, 8'h7e, 16'hf010, 16'h0, q);
    chk("outside page", q, 16'h0);
    $display("Test word done");
  endtask
  task automatic t_block;
    cpu.tbl(1'b0, 8'h7f, 16'hf03e, 16'h0, q);
    run_op(16'h4045, 1'b0);
    cpu.tbl(1'b0, 8'h7f, 16'hf020, 16'h0, q);
    chk("block erased", q, `NVMWS_ERASED);
    for (int i = 0; i < 16; i++) cpu.tbl(1'b1, 8'h7f, 16'hf020 + 16'(2 * i), 16'ha500 + 16'(i), q);
    run_op(16'h400a, 1'b0);
    for (int i = 0; i < 16; i++) begin
      cpu.tbl(1'b0, 8'h7f, 16'hf020 + 16'(2 * i), 16'h0, q);
      chk("block word", q, 16'ha500 + 16'(i));
    end
    $display("Test block done");
  endtask
  task automatic t_lock;
    logic [31:0] s [4][5];
    s = '{'{{C, 16'h0044}, {C, 16'h0044}, {K, 16'h0055}, {K, 16'h00aa}, {C, 16'hc044}},
          '{{C, 16'h4044}, {C, 16'h4044}, {K, 16'h00aa}, {K, 16'h0055}, {C, 16'hc044}},
          '{{C, 16'h4044}, {K, 16'h0055}, {16'h0700, 16'h0}, {K, 16'h00aa}, {C, 16'hc044}},
          '{{C, 16'h4044}, {K, 16'h0055}, {K, 16'h00aa}, {C, 16'h4044}, {C, 16'hc044}}};
    for (int r = 0; r < 4; r++) begin
      for (int j = 0; j < 5; j++) cpu.sfr(1'b1, s[r][j][31:16], s[r][j][15:0], q);
      cpu.sfr(1'b0, C, 16'h0, q);
      chk("start refused", q, 16'h4044);
    end
    repeat (CYC + 4) @(posedge clk);
    #1;
    chk("no completion", {15'h0, done_flag}, 16'h0);
    $display("Test lock done");
  endtask
  task automatic t_abort;
    cpu.tbl(1'b0, 8'h7f, 16'hf00c, 16'h0, q);
    cpu.unlock_start(16'h4044);
    cpu.sfr(1'b1, C, 16'h4044, q);
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("start held", q, 16'hc044);
    pulse(1'b1);
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("error bit", q, 16'h2000);
    cpu.sfr(1'b0, `NVMWS_ADR_LO, 16'h0, q);
    chk("addr kept", q, 16'hf00c);
    repeat (CYC + 4) @(posedge clk);
    #1;
    chk("aborted no flag", {15'h0, done_flag}, 16'h0);
    cpu.sfr(1'b1, C, 16'h0000, q);
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("error cleared", q, 16'h0000);
    $display("Test abort done");
  endtask
  // A write while the clock enable is low must leave the control register alone
  task automatic t_freeze;
    ce = 1'b0;
    cpu.sfr(1'b1, C, 16'h4044, q);
    ce = 1'b1;
    cpu.sfr(1'b0, C, 16'h0, q);
    chk("frozen write", q, 16'h0000);
    $display("Test freeze done");
  endtask
  task automatic t_flash;
    run_op(16'h4001, 1'b1);
    $display("Test flash done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    master_clear_reset = 1'b0;
    clr = 1'b0;
    ce = 1'b1;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_word();
    t_block();
    t_lock();
    t_abort();
    t_freeze();
    t_flash();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
